/* src/sdp_phy_params.svh */
/*
 * constants of the single-wire debug link physical-layer configuration:
 * register offsets, field positions, reset values and timing counts.
 * assumes it is included by bare name before the package and the module.
 */
`ifndef SDP_PHY_PARAMS_SVH
`define SDP_PHY_PARAMS_SVH

// register offsets on the link's own register access port
`define SDP_OFS_ERR_STATUS 4'h1
`define SDP_OFS_CTRL_A 4'h2
`define SDP_OFS_CTRL_B 4'h3
`define SDP_OFS_KEY_STATE 4'h7
`define SDP_OFS_RST_REQ 4'h8

// phy_control_a fields
`define SDP_A_IBD_BIT 7
`define SDP_A_PAR_BIT 5
`define SDP_A_TMO_BIT 4
`define SDP_A_RSP_BIT 3
`define SDP_A_GT_MSB 2
`define SDP_A_GT_LSB 0
`define SDP_A_WMASK 8'hbf

// phy_control_b fields
`define SDP_B_NACK_BIT 4
`define SDP_B_COLL_BIT 3
`define SDP_B_DIS_BIT 2
`define SDP_B_WMASK 8'h18

// key_state fields
`define SDP_K_UROW_BIT 5
`define SDP_K_PROG_BIT 4
`define SDP_K_ERASE_BIT 3

// reset values
`define SDP_RST_CTRL_A 8'h00
`define SDP_RST_CTRL_B 8'h00
`define SDP_RST_SIG_FIELD 3'h0

// system reset request signature
`define SDP_RST_SIGNATURE 8'h59

// timing counts
`define SDP_TIMEOUT_CYCLES 65536
`define SDP_GT_BASE 8'h80
`define SDP_GT_OFF 3'h7
`define SDP_IDLE_CHAR_BITS 12
`define SDP_IBD_CHARS 2

`endif

/* src/sdp_phy_pkg.sv */
/*
 * types of the single-wire debug link physical-layer configuration.
 * assumes sdp_phy_params.svh holds the numeric constants.
 */
package sdp_phy_pkg;
    typedef enum logic [2:0] {
        SDP_ERR_NONE = 3'h0,
        SDP_ERR_PARITY = 3'h1,
        SDP_ERR_FRAME = 3'h2,
        SDP_ERR_TIMEOUT = 3'h3,
        SDP_ERR_START = 3'h4,
        SDP_ERR_CONTENTION = 3'h7
    } sdp_err_t;

    typedef enum logic [1:0] {
        SDP_TX_IDLE = 2'b00,
        SDP_TX_GUARD = 2'b01,
        SDP_TX_SEND = 2'b11,
        SDP_TX_GAP = 2'b10
    } sdp_tx_state_t;
endpackage : sdp_phy_pkg

/* src/sdp_phy_cfg.sv */
/*
 * configuration and status logic of the single-wire debug link phy:
 * error signature, transmit pacing (guard time, inter-byte gap), access
 * timeout, key flags, system reset request and phy disable.
 * assumes every input comes from link logic on clk_sys and that the
 * register port is driven by the link's own register instructions.
 */
// How it works
// - error field loads the highest-priority flagged link error, clears when debugger reads it
// - codes 1 parity, 2 stop bit, 4 start bit, 7 contention
// - code 3 when access layer gives no answer in time
// - with inter-byte delay on, two idle characters separate load bytes
// - parity ignore set means parity errors are never flagged
// - access answer needed within 65536 cycles unless timeout detect off
// - response signature off suppresses every response signature
// - guard after receive-to-transmit is 128 halving to 2, 7 means none
// - each guard cycle lasts one bit period of the link
// - nack suppress stops nack on system reset during load or store
// - collision detection active while collision detect off is zero
// - phy disable drops clock request and resets settings and keys
// - key bit 5 shows user-row write key active
// - key bit 4 shows programming key, clears when programming ends
// - key bit 3 shows erase key, clears when erase completes
// - 0x59 asserts system reset, other values release, bit 0 reads it
`timescale 1ns/1ps
`include "sdp_phy_params.svh"

module sdp_phy_cfg #(
    parameter int TIMEOUT_CYCLES = `SDP_TIMEOUT_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // register access from the link instruction decoder
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // receiver error events
    input wire logic err_parity,
    input wire logic err_stop,
    input wire logic err_start,
    input wire logic err_contention,
    // access layer handshake
    input wire logic acc_start,
    input wire logic acc_done,
    output logic acc_timeout,
    // transmit pacing
    input wire logic bit_tick,
    input wire logic tx_req,
    input wire logic tx_first,
    input wire logic multi_load,
    input wire logic tx_done,
    output logic tx_start,
    // protocol controls
    input wire logic ldst_active,
    input wire logic sys_in_reset,
    output logic nack_send,
    output logic response_sig_off,
    output logic parity_ignore,
    output logic collision_detect_off,
    // key decoder
    input wire logic key_urow_set,
    input wire logic key_prog_set,
    input wire logic key_erase_set,
    input wire logic prog_done,
    input wire logic erase_done,
    // system side
    input wire logic link_wake,
    output logic system_reset_request,
    output logic phy_clk_req,
    output logic link_rst
);
    import sdp_phy_pkg::*;

    logic [7:0] ctrl_a;
    logic nack_suppress;
    logic [2:0] error_signature;
    logic user_row_key_active;
    logic mem_prog_key_active;
    logic erase_key_active;
    logic phy_disable;
    logic wr_a;
    logic wr_b;
    logic rd_err;
    logic [2:0] guard_time_sel;
    logic inter_byte_delay_en;
    logic timeout_detect_off;

    assign wr_a = reg_wr && reg_addr == `SDP_OFS_CTRL_A;
    assign wr_b = reg_wr && reg_addr == `SDP_OFS_CTRL_B;
    assign rd_err = reg_rd && reg_addr == `SDP_OFS_ERR_STATUS;
    assign guard_time_sel = ctrl_a[`SDP_A_GT_MSB:`SDP_A_GT_LSB];
    assign inter_byte_delay_en = ctrl_a[`SDP_A_IBD_BIT];
    assign timeout_detect_off = ctrl_a[`SDP_A_TMO_BIT];
    // disable acts on the written value; the bit itself never sticks
    assign phy_disable = wr_b && reg_wdata[`SDP_B_DIS_BIT];

    // link reset pulse and clock request
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            link_rst <= 1'b0;
            phy_clk_req <= 1'b1;
        end else if (phy_disable) begin
            link_rst <= 1'b1;
            phy_clk_req <= 1'b0;
        end else begin
            link_rst <= 1'b0;
            if (link_wake) begin
                phy_clk_req <= 1'b1;
            end
        end
    end

    // control registers
    always_ff @(posedge clk_sys) begin
        if (!nrst || phy_disable) begin
            ctrl_a <= `SDP_RST_CTRL_A;
            nack_suppress <= 1'b0;
            collision_detect_off <= 1'b0;
        end else begin
            if (wr_a) begin
                ctrl_a <= reg_wdata & `SDP_A_WMASK;
            end
            if (wr_b) begin
                nack_suppress <= reg_wdata[`SDP_B_NACK_BIT];
                collision_detect_off <= reg_wdata[`SDP_B_COLL_BIT];
            end
        end
    end

    // copies for the receiver and protocol engine, kept as flops
    always_ff @(posedge clk_sys) begin
        if (!nrst || phy_disable) begin
            parity_ignore <= 1'b0;
            response_sig_off <= 1'b0;
        end else begin
            parity_ignore <= wr_a ? reg_wdata[`SDP_A_PAR_BIT]
                                  : ctrl_a[`SDP_A_PAR_BIT];
            response_sig_off <= wr_a ? reg_wdata[`SDP_A_RSP_BIT]
                                     : ctrl_a[`SDP_A_RSP_BIT];
        end
    end

    // access layer timeout; an answer in the last cycle still counts
    logic acc_wait;
    logic [16:0] acc_cnt;
    logic tmo_hit;
    assign tmo_hit = acc_wait && !timeout_detect_off
        && acc_cnt == 17'(TIMEOUT_CYCLES - 1);

    always_ff @(posedge clk_sys) begin
        if (!nrst || phy_disable) begin
            acc_wait <= 1'b0;
            acc_cnt <= 17'h0_0000;
            acc_timeout <= 1'b0;
        end else begin
            acc_timeout <= tmo_hit && !acc_done;
            if (acc_start) begin
                acc_wait <= 1'b1;
                acc_cnt <= 17'h0_0000;
            end else if (acc_done || tmo_hit) begin
                acc_wait <= 1'b0;
            end else if (acc_wait && !timeout_detect_off) begin
                acc_cnt <= acc_cnt + 17'h0_0001;
            end
        end
    end

    // error signature; a new error beats a clearing read
    sdp_err_t next_err;
    always_comb begin
        next_err = SDP_ERR_NONE;
        if (err_contention && !collision_detect_off) begin
            next_err = SDP_ERR_CONTENTION;
        end else if (err_start) begin
            next_err = SDP_ERR_START;
        end else if (err_stop) begin
            next_err = SDP_ERR_FRAME;
        end else if (err_parity && !parity_ignore) begin
            next_err = SDP_ERR_PARITY;
        end else if (acc_timeout) begin
            next_err = SDP_ERR_TIMEOUT;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst || phy_disable) begin
            error_signature <= `SDP_RST_SIG_FIELD;
        end else if (next_err != SDP_ERR_NONE) begin
            error_signature <= next_err;
        end else if (rd_err) begin
            error_signature <= `SDP_RST_SIG_FIELD;
        end
    end

    // nack on a system reset that lands inside a load or store
    logic sys_rst_q;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sys_rst_q <= 1'b0;
            nack_send <= 1'b0;
        end else begin
            sys_rst_q <= sys_in_reset;
            nack_send <= sys_in_reset && !sys_rst_q && ldst_active
                && !nack_suppress;
        end
    end

    // keys; a set in the same cycle as its clear wins
    always_ff @(posedge clk_sys) begin
        if (!nrst || phy_disable) begin
            user_row_key_active <= 1'b0;
            mem_prog_key_active <= 1'b0;
            erase_key_active <= 1'b0;
        end else begin
            if (key_urow_set) begin
                user_row_key_active <= 1'b1;
            end
            if (key_prog_set) begin
                mem_prog_key_active <= 1'b1;
            end else if (prog_done) begin
                mem_prog_key_active <= 1'b0;
            end
            if (key_erase_set) begin
                erase_key_active <= 1'b1;
            end else if (erase_done) begin
                erase_key_active <= 1'b0;
            end
        end
    end

    // system reset request; the link itself stays out of this reset
    always_ff @(posedge clk_sys) begin
        if (!nrst || phy_disable) begin
            system_reset_request <= 1'b0;
        end else if (reg_wr && reg_addr == `SDP_OFS_RST_REQ) begin
            system_reset_request <= reg_wdata == `SDP_RST_SIGNATURE;
        end
    end

    // register reads, answered one cycle after the request
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            `SDP_OFS_ERR_STATUS: begin
                rd_mux = {5'h00, error_signature};
            end
            `SDP_OFS_CTRL_A: begin
                rd_mux = ctrl_a;
            end
            `SDP_OFS_CTRL_B: begin
                rd_mux[`SDP_B_NACK_BIT] = nack_suppress;
                rd_mux[`SDP_B_COLL_BIT] = collision_detect_off;
            end
            `SDP_OFS_KEY_STATE: begin
                rd_mux[`SDP_K_UROW_BIT] = user_row_key_active;
                rd_mux[`SDP_K_PROG_BIT] = mem_prog_key_active;
                rd_mux[`SDP_K_ERASE_BIT] = erase_key_active;
            end
            `SDP_OFS_RST_REQ: begin
                rd_mux = {7'h00, system_reset_request};
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end

    // transmit pacing, counted in bit periods of the link
    sdp_tx_state_t tx_state;
    sdp_tx_state_t next_tx_state;
    logic [7:0] pace_cnt;
    logic [7:0] next_pace_cnt;
    logic next_tx_start;
    logic [7:0] guard_len;
    // guard halves per step; 7 would still shift to 1, so it is caught apart as none
    assign guard_len = (guard_time_sel == `SDP_GT_OFF) ? 8'h00
                     : (`SDP_GT_BASE >> guard_time_sel);

    always_comb begin
        next_tx_state = tx_state;
        next_pace_cnt = pace_cnt;
        next_tx_start = 1'b0;
        unique case (tx_state)
            SDP_TX_IDLE: begin
                if (tx_req && tx_first && guard_len != 8'h00) begin
                    next_tx_state = SDP_TX_GUARD;
                    next_pace_cnt = guard_len;
                end else if (tx_req && !tx_first && multi_load
                        && inter_byte_delay_en) begin
                    next_tx_state = SDP_TX_GAP;
                    next_pace_cnt = 8'(`SDP_IBD_CHARS
                        * `SDP_IDLE_CHAR_BITS);
                end else if (tx_req) begin
                    next_tx_state = SDP_TX_SEND;
                    next_tx_start = 1'b1;
                end
            end
            SDP_TX_GUARD, SDP_TX_GAP: begin
                if (bit_tick) begin
                    next_pace_cnt = pace_cnt - 8'h01;
                    if (pace_cnt == 8'h01) begin
                        next_tx_state = SDP_TX_SEND;
                        next_tx_start = 1'b1;
                    end
                end
            end
            SDP_TX_SEND: begin
                if (tx_done) begin
                    next_tx_state = SDP_TX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst || phy_disable) begin
            tx_state <= SDP_TX_IDLE;
            pace_cnt <= 8'h00;
            tx_start <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            pace_cnt <= next_pace_cnt;
            tx_start <= next_tx_start;
        end
    end
endmodule : sdp_phy_cfg

/* verification/sdp_phy_cfg_sva.sv */
/* assertions on the ports of sdp_phy_cfg.
   assumes clk_sys and the synchronous nrst of the block. */
`timescale 1ns/1ps
`include "sdp_phy_params.svh"
module sdp_phy_cfg_sva #(parameter int TIMEOUT_CYCLES = 16) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // events
    input wire logic err_parity,
    input wire logic err_stop,
    input wire logic err_start,
    input wire logic err_contention,
    input wire logic acc_done,
    input wire logic acc_timeout,
    // controls
    input wire logic parity_ignore,
    input wire logic response_sig_off,
    input wire logic collision_detect_off,
    input wire logic system_reset_request,
    input wire logic phy_clk_req,
    input wire logic link_rst
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // a read clears the field only when no error lands in the same cycle
    wire logic quiet = !(err_parity || err_stop || err_start ||
        err_contention || acc_timeout);
    wire logic wa = reg_wr && reg_addr == `SDP_OFS_CTRL_A;
    wire logic wb = reg_wr && reg_addr == `SDP_OFS_CTRL_B;
    wire logic wq = reg_wr && reg_addr == `SDP_OFS_RST_REQ;
    property p_rvalid; reg_rd |=> reg_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("no read answer");
    property p_sig_clear;
        (reg_rd && reg_addr == `SDP_OFS_ERR_STATUS && quiet) ##1 quiet
        ##1 (reg_rd && reg_addr == `SDP_OFS_ERR_STATUS && quiet)
        |=> reg_rdata == 8'h00;
    endproperty
    a_sig_clear: assert property (p_sig_clear)
        else $error("error field not cleared by read");
    property p_parity_ignore; wa |=> parity_ignore == $past(reg_wdata[5]); endproperty
    a_parity_ignore: assert property (p_parity_ignore) else $error("parity ignore");
    property p_rsd; wa |=> response_sig_off == $past(reg_wdata[3]); endproperty
    a_rsd: assert property (p_rsd) else $error("signature off");
    property p_coll;
        wb && !reg_wdata[2] |=> collision_detect_off == $past(reg_wdata[3]);
    endproperty
    a_coll: assert property (p_coll) else $error("collision off");
    property p_dis;
        wb && reg_wdata[2] |=> link_rst && !phy_clk_req && !parity_ignore;
    endproperty
    a_dis: assert property (p_dis) else $error("disable");
    property p_rst_set;
        wq && reg_wdata == `SDP_RST_SIGNATURE |=> system_reset_request;
    endproperty
    a_rst_set: assert property (p_rst_set) else $error("reset set");
    property p_rst_clr;
        wq && reg_wdata != `SDP_RST_SIGNATURE |=> !system_reset_request;
    endproperty
    a_rst_clr: assert property (p_rst_clr) else $error("reset clr");
    property p_rst_rd;
        reg_rd && reg_addr == `SDP_OFS_RST_REQ
        |=> reg_rdata == {7'h00, $past(system_reset_request)};
    endproperty
    a_rst_rd: assert property (p_rst_rd) else $error("reset read");
    property p_tmo; acc_done |=> !acc_timeout; endproperty
    a_tmo: assert property (p_tmo) else $error("timeout after answer");
endmodule : sdp_phy_cfg_sva

bind sdp_phy_cfg sdp_phy_cfg_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sva (
    .clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .err_parity(err_parity), .err_stop(err_stop),
    .err_start(err_start), .err_contention(err_contention),
    .acc_done(acc_done), .acc_timeout(acc_timeout),
    .parity_ignore(parity_ignore), .response_sig_off(response_sig_off),
    .collision_detect_off(collision_detect_off),
    .system_reset_request(system_reset_request),
    .phy_clk_req(phy_clk_req), .link_rst(link_rst));

/* verification/sdp_acc_model.sv */
/* access layer and bit clock seen from the link phy.
   assumes mode 0 prompt, 1 slow, 2 mute (system asleep). */
`timescale 1ns/1ps
module sdp_acc_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // request side
    input wire logic acc_start,
    input wire logic [1:0] mode,
    output logic acc_done,
    output logic bit_tick
);
    logic [3:0] cnt;
    logic busy;
    // one bit period is two clocks, so pacing is counted in ticks
    always_ff @(posedge clk_sys) begin
        bit_tick <= nrst && !bit_tick;
    end
    always_ff @(posedge clk_sys) begin
        acc_done <= 1'b0;
        if (!nrst) begin
            busy <= 1'b0;
        end else if (acc_start) begin
            busy <= mode != 2'h2;
            cnt <= (mode == 2'h0) ? 4'h1 : 4'ha;
        end else if (busy) begin
            cnt <= cnt - 4'h1;
            busy <= cnt != 4'h1;
            acc_done <= cnt == 4'h1;
        end
    end
endmodule : sdp_acc_model

/* verification/tb_single_wire_debug_phy_config.sv */
/* self-checking bench of sdp_phy_cfg with an access layer model.
   assumes the checker is bound to the design. */
`timescale 1ns/1ps
`include "sdp_phy_params.svh"
`define CK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_single_wire_debug_phy_config;
    import sdp_phy_pkg::*;
    logic clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, tx_req = 0;
    logic tx_first = 0, multi_load = 0, ldst = 0, sysr = 0, t;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, rd_v;
    logic [11:0] ev = 0;
    logic [1:0] mode = 0;
    logic [7:0] rdata;
    logic rvalid, done, tmo, tick, txs, nack, rso, pig, cdo, srr, ckr, lrst;
    int fail_count = 0, checked = 0, b, n;
    int code[4] = '{1, 2, 4, 7};
    sdp_phy_cfg #(.TIMEOUT_CYCLES(16)) uut (.clk_sys(clk_sys), .nrst(nrst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .err_parity(ev[0]), .err_stop(ev[1]), .err_start(ev[2]),
        .err_contention(ev[3]), .acc_start(ev[10]), .acc_done(done),
        .acc_timeout(tmo), .bit_tick(tick), .tx_req(tx_req),
        .tx_first(tx_first), .multi_load(multi_load), .tx_done(ev[11]),
        .tx_start(txs), .ldst_active(ldst), .sys_in_reset(sysr),
        .nack_send(nack), .response_sig_off(rso), .parity_ignore(pig),
        .collision_detect_off(cdo), .key_urow_set(ev[4]),
        .key_prog_set(ev[5]), .key_erase_set(ev[6]), .prog_done(ev[7]),
        .erase_done(ev[8]), .link_wake(ev[9]), .system_reset_request(srr),
        .phy_clk_req(ckr), .link_rst(lrst));
    sdp_acc_model u_host (.clk_sys(clk_sys), .nrst(nrst), .acc_start(ev[10]),
        .mode(mode), .acc_done(done), .bit_tick(tick));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(negedge clk_sys);
        reg_rd = 1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 0;
        rd_v = rdata;
        `CK("read valid", 1'b1, rvalid)
    endtask : rd
    task automatic pl(input int i);
        @(negedge clk_sys);
        ev[i] = 1;
        @(negedge clk_sys);
        ev[i] = 0;
    endtask : pl
    task automatic watch(input logic s);
        t = 0;
        repeat (40) begin
            @(negedge clk_sys);
            t = t | (s ? nack : tmo);
        end
    endtask : watch
    // start on a fixed tick phase so tick counts compare exactly
    task automatic tx(input logic f, input logic m, output int c);
        do @(negedge clk_sys); while (tick !== 1'b1);
        @(negedge clk_sys);
        tx_req = 1;
        tx_first = f;
        multi_load = m;
        c = 0;
        for (int k = 0; k < 600 && txs !== 1'b1; k++) begin
            @(negedge clk_sys);
            c = c + (txs === 1'b1 ? 0 : int'(tick));
        end
        tx_req = 0;
        pl(11);
    endtask : tx
    task automatic t_regs;
        foreach (code[i]) begin
            rd(4'(i + 1));
            `CK("reset value", 8'h00, rd_v)
        end
        `CK("clock request", 1'b1, ckr)
        wr(2, 8'hff);
        rd(2);
        `CK("ctrl a", 8'hbf, rd_v)
        `CK("signature off", 1'b1, rso)
        wr(3, 8'hfb);
        rd(3);
        `CK("ctrl b", 8'h18, rd_v)
        wr(7, 8'hff);
        rd(7);
        `CK("key state", 8'h00, rd_v)
        wr(5, 8'hff);
        rd(5);
        `CK("unmapped", 8'h00, rd_v)
        wr(3, 8'h00);
        wr(2, 8'h00);
    endtask : t_regs
    task automatic t_err;
        foreach (code[i]) begin
            pl(i);
            rd(1);
            `CK("error code", 8'(code[i]), rd_v)
            rd(1);
            `CK("error cleared", 8'h00, rd_v)
        end
        pl(0);
        pl(1);
        rd(1);
        `CK("newest error", 8'h02, rd_v)
        wr(2, 8'h20);
        `CK("parity ignore out", 1'b1, pig)
        pl(0);
        rd(1);
        `CK("parity ignored", 8'h00, rd_v)
        wr(3, 8'h08);
        `CK("collision off out", 1'b1, cdo)
        pl(3);
        rd(1);
        `CK("contention off", 8'h00, rd_v)
        wr(3, 8'h00);
        wr(2, 8'h00);
    endtask : t_err
    task automatic t_tmo;
        mode = 2;
        pl(10);
        watch(0);
        `CK("timeout", 1'b1, t)
        rd(1);
        `CK("timeout code", 8'h03, rd_v)
        mode = 1;
        pl(10);
        watch(0);
        `CK("slow answer", 1'b0, t)
        wr(2, 8'h10);
        mode = 2;
        pl(10);
        watch(0);
        `CK("timeout off", 1'b0, t)
        mode = 0;
        wr(2, 8'h00);
    endtask : t_tmo
    task automatic t_tx;
        wr(2, 8'h07);
        tx(1, 0, b);
        for (int s = 0; s < 7; s++) begin
            wr(2, 8'(s));
            tx(1, 0, n);
            `CK("guard ticks", 128 >> s, n - b)
        end
        wr(2, 8'h87);
        tx(1, 1, n);
        `CK("first byte", b, n)
        tx(0, 1, n);
        `CK("byte gap", `SDP_IBD_CHARS * `SDP_IDLE_CHAR_BITS, n - b)
        wr(2, 8'h00);
    endtask : t_tx
    task automatic t_misc;
        wr(8, 8'h59);
        rd(8);
        `CK("reset request", 8'h01, rd_v)
        wr(8, 8'h58);
        `CK("reset release", 1'b0, srr)
        ldst = 1;
        sysr = 1;
        watch(1);
        `CK("nack", 1'b1, t)
        sysr = 0;
        wr(3, 8'h10);
        sysr = 1;
        watch(1);
        `CK("nack suppressed", 1'b0, t)
        sysr = 0;
        for (int i = 4; i < 7; i++) pl(i);
        rd(7);
        `CK("keys", 8'h38, rd_v)
        pl(7);
        pl(8);
        rd(7);
        `CK("keys after done", 8'h20, rd_v)
        wr(2, 8'h20);
        wr(8, 8'h59);
        wr(3, 8'h04);
        `CK("link reset", 1'b1, lrst)
        `CK("clock dropped", 1'b0, ckr)
        `CK("reset released", 1'b0, srr)
        pl(9);
        `CK("clock back", 1'b1, ckr)
        rd(7);
        `CK("keys reset", 8'h00, rd_v)
        rd(2);
        `CK("config reset", 8'h00, rd_v)
    endtask : t_misc
    task automatic report_and_stop;
        if (fail_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #800000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1;
        t_regs();
        t_err();
        t_tmo();
        t_tx();
        t_misc();
        report_and_stop();
    end
endmodule : tb_single_wire_debug_phy_config
